// *** rtl/wdt_pkg.sv ***
// Package of constants and types shared by the watchdog ends
package wdt_pkg;
	// ************************************************************
	// Control register layout
	// ************************************************************
	localparam int          WDT_ARM_BIT     = 7;
	localparam int          WDT_DISARM_BIT  = 6;
	localparam int          WDT_KICK_BIT    = 5;
	localparam int          WDT_TMO_LSB     = 0;
	localparam int          WDT_TMO_W       = 5;
	localparam logic [7:0]  WDT_CTRL_RST    = 8'h00;
	// Extended interrupt control, enable and wake register bits
	localparam int          WDT_FLAG_BIT    = 3;
	localparam int          WDT_IEN_BIT     = 4;
	localparam int          WDT_WAKE_BIT    = 2;
	localparam logic [15:0] WDT_VECTOR      = 16'h0063;
	localparam logic [15:0] WDT_RST_VECTOR  = 16'h0000;
	// ************************************************************
	// Controller register map
	// ************************************************************
	localparam logic [3:0]  WDC_CMD_OFS     = 4'h0;
	localparam logic [3:0]  WDC_TMO_OFS     = 4'h1;
	localparam logic [3:0]  WDC_CFG_OFS     = 4'h2;
	localparam logic [3:0]  WDC_STAT_OFS    = 4'h3;
	localparam logic [3:0]  WDC_IEN_OFS     = 4'h4;
	localparam logic [3:0]  WDC_ICLR_OFS    = 4'h5;
	localparam logic [3:0]  WDC_LINK_OFS    = 4'h6;
	// Command codes in the command register
	localparam logic [7:0]  WDC_CMD_ARM     = 8'h01;
	localparam logic [7:0]  WDC_CMD_KICK    = 8'h02;
	localparam logic [7:0]  WDC_CMD_DISARM  = 8'h03;
	localparam logic [7:0]  WDC_CMD_TMO     = 8'h04;
	localparam logic [7:0]  WDC_CMD_FCLR    = 8'h05;
	// Event bits in controller status
	localparam int          WDC_EV_DONE     = 0;
	localparam int          WDC_EV_EXPIRY   = 1;
	localparam int          WDC_EV_RESET    = 2;
	// ************************************************************
	// Tick source timing
	// ************************************************************
	localparam int          WDT_CLK_MHZ     = 50;
	localparam int          WDT_TICK_US     = 1000;
	localparam int          WDT_TICK_CYC    = WDT_TICK_US * WDT_CLK_MHZ;
	typedef enum logic [1:0] {WDC_IDLE, WDC_SET, WDC_CLR} wdt_seq_t;
endpackage

// *** rtl/wdt_if.sv ***
// Interface joining the watchdog to its processor-side controller
`timescale 1ns/10ps
interface wdt_if;
	logic       ctrl_wr;      // Control register write strobe
	logic [7:0] ctrl_wdata;   // Control register write data
	logic [7:0] ctrl_rdata;   // Control register read back
	logic       irq_flag;     // Expiry interrupt flag
	logic       irq_flag_clr; // Clear pulse for the flag
	logic       irq_en;       // Expiry interrupt enable
	logic       global_en;    // Global interrupt enable
	logic       wake_en;      // Wake on expiry enable
	logic       idle;         // Processor in idle mode
	logic       irq_take;     // Interrupt taken, vector below
	logic [15:0] irq_vector;  // Vector of the taken interrupt
	logic       wake;         // Wake from idle
	logic       chip_rst;     // Watchdog chip reset pulse
	logic       running;      // Countdown active
	modport dev (
		input  ctrl_wr, ctrl_wdata, irq_flag_clr, irq_en, global_en,
		input  wake_en, idle,
		output ctrl_rdata, irq_flag, irq_take, irq_vector, wake,
		output chip_rst, running
	);
	modport host (
		output ctrl_wr, ctrl_wdata, irq_flag_clr, irq_en, global_en,
		output wake_en, idle,
		input  ctrl_rdata, irq_flag, irq_take, irq_vector, wake,
		input  chip_rst, running
	);
endinterface

// *** rtl/wdt_core.sv ***
// Watchdog timer device end
`timescale 1ns/10ps
module wdt_core
	import wdt_pkg::*;
#(
	parameter int TICK_CYC = WDT_TICK_CYC
)(
	input  wire logic core_clk,
	input  wire logic arst_n,
	input  wire logic expiry_action_select,
	wdt_if.dev        bus
);
	logic [7:0]  ctrl_reg;
	logic        run_reg;
	logic [4:0]  tmo_src;
	logic [5:0]  cnt_reg;
	logic [15:0] tick_reg;
	logic        flag_reg;
	logic        rst_reg;
	logic        tick;
	logic        expire;
	logic        arm_fall;
	logic        kick_fall;
	logic        dis_fall;

	// ************************************************************
	// Strobe detection
	// ************************************************************
	// One-to-zero of a stored bit on a write marks a sequence
	function automatic logic fell(input logic [7:0] old_v,
		input logic [7:0] new_v, input int b);
		return old_v[b] && !new_v[b];
	endfunction
	assign arm_fall  = bus.ctrl_wr && fell(ctrl_reg, bus.ctrl_wdata,
		WDT_ARM_BIT);
	assign kick_fall = bus.ctrl_wr && fell(ctrl_reg, bus.ctrl_wdata,
		WDT_KICK_BIT);
	assign dis_fall  = bus.ctrl_wr && fell(ctrl_reg, bus.ctrl_wdata,
		WDT_DISARM_BIT);

	// Control register storage
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ctrl_reg <= WDT_CTRL_RST;
		else if (bus.ctrl_wr)
			ctrl_reg <= bus.ctrl_wdata;
	end

	// ************************************************************
	// Countdown
	// ************************************************************
	// Free tick prescaler; not restarted on kick, hence one tick slack
	assign tick = (tick_reg == 16'(TICK_CYC - 1));
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			tick_reg <= '0;
		else if (tick)
			tick_reg <= '0;
		else
			tick_reg <= tick_reg + 16'd1;
	end

	assign expire = run_reg && tick && (cnt_reg == 6'd1);

	// Run state; action select is not consulted here
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			run_reg <= 1'b0;
		else if (dis_fall)
			run_reg <= 1'b0;
		else if (arm_fall)
			run_reg <= 1'b1;
	end

	// Timeout source: the write in flight wins over the stored copy,
	// so the clearing write of a sequence may carry a new timeout
	function automatic logic [4:0] tmo_pick(input logic wr_v,
		input logic [7:0] wdata_v, input logic [7:0] stored_v);
		if (wr_v)
			return wdata_v[WDT_TMO_W-1:0];
		return stored_v[WDT_TMO_W-1:0];
	endfunction
	assign tmo_src = tmo_pick(bus.ctrl_wr, bus.ctrl_wdata, ctrl_reg);

	// Counter reloads only at arm, kick or expiry, never on a plain write
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_reg <= '0;
		else if (arm_fall || kick_fall || expire)
			cnt_reg <= {1'b0, tmo_src} + 6'd1;
		else if (run_reg && tick)
			cnt_reg <= cnt_reg - 6'd1;
	end

	// ************************************************************
	// Expiry action
	// ************************************************************
	// Chip reset pulse; the host restarts at address zero
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			rst_reg <= 1'b0;
		else
			rst_reg <= expire && expiry_action_select;
	end

	// Flag: set wins over clear so no expiry is lost
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			flag_reg <= 1'b0;
		else if (expire && !expiry_action_select)
			flag_reg <= 1'b1;
		else if (bus.irq_flag_clr)
			flag_reg <= 1'b0;
	end

	// Interrupt taking and idle wake
	assign bus.irq_take   = flag_reg && bus.irq_en && bus.global_en
		&& !bus.idle;
	assign bus.irq_vector = WDT_VECTOR;
	assign bus.wake       = flag_reg && bus.idle && bus.wake_en;
	assign bus.irq_flag   = flag_reg;
	assign bus.chip_rst   = rst_reg;
	assign bus.running    = run_reg;
	assign bus.ctrl_rdata = ctrl_reg;

	// ************************************************************
	// Integration notes
	// ************************************************************
	// Strobe sequences are seen only through the stored control word.
	// A write that clears a strobe bit which was set acts at once;
	// writing the same bit low twice does nothing the second time.
	// Several strobe bits may fall in one write; disarm then wins.
	// Arm and kick in one write both reload, which is harmless.
	//
	// The prescaler runs free from reset and is never restarted.
	// Restarting it on every kick would give an exact interval but
	// would let a fast kicker starve the tick; the free counter
	// instead costs up to one tick of slack on the first period.
	// Software must therefore kick well inside the shortest period,
	// that is within the programmed timeout, not timeout plus one.
	//
	// A timeout written while the countdown runs is only stored.
	// It takes effect at the next kick or at the next expiry, since
	// the counter reloads at both, from the clearing write at a kick and from the stored word at an expiry.
	// After an expiry in interrupt mode the countdown carries on,
	// so an unserviced program sees the flag again each period.
	//
	// The expiry action input is a fixed configuration level.
	// It picks reset or interrupt and nothing else; counting is
	// started and stopped by software sequences alone.
	// Changing it while running takes effect at the next expiry.
	//
	// The chip reset output is a single clock pulse. The host side
	// stretches or synchronises it as its own reset tree needs.
	// This block does not disarm itself on that pulse: the host is
	// expected to drive the async reset, which clears all state.
	// Data memory is outside this block and is left alone.
	//
	// The expiry flag is set by an expiry in interrupt mode and cleared by a clear pulse.
	// When both arrive in one cycle the set wins, so no expiry can
	// be lost between the handler reading the flag and clearing it.
	// A handler that returns without clearing the flag is taken
	// again, as the take output stays high while the flag is set.
	//
	// Interrupt taking is blocked in idle; instead the wake output
	// rises when the wake enable is set. Without it an expiry in
	// idle leaves the processor asleep with the flag pending.
	// The vector output is a constant and is valid with the take.
	//
	// Limitation: the counter is six bits wide, enough for the
	// largest timeout plus one; widening the field needs both the
	// package width and this counter to grow together.
	// Limitation: the prescaler is sixteen bits wide, so a tick
	// longer than that many clock cycles needs a wider counter.
endmodule

// *** rtl/wdt_ctl.sv ***
// Processor-side controller that drives the watchdog sequences
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module wdt_ctl
	import wdt_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            irq,
	output logic            cpu_restart,
	output logic     [15:0] restart_pc,
	wdt_if.host             bus
);
	logic [4:0]  tmo_reg;
	logic [3:0]  cfg_reg;
	logic [2:0]  stat_reg;
	logic [2:0]  ien_reg;
	logic [7:0]  shadow_reg;
	logic [7:0]  wdata_reg;
	logic        wr_reg;
	logic [7:0]  rdata_reg;
	logic [15:0] pc_reg;
	logic        restart_reg;
	logic        fclr_reg;
	wdt_seq_t    seq_reg;
	logic [7:0]  bit_reg;
	logic        cmd_wr;
	logic        seq_done;
	logic [2:0]  ev;
	logic        flag_prev_reg;

	// ************************************************************
	// Software registers
	// ************************************************************
	assign cmd_wr = wr && addr == WDC_CMD_OFS && seq_reg == WDC_IDLE;
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tmo_reg <= '0;
			cfg_reg <= '0;
			ien_reg <= '0;
		end
		else if (wr)
		begin
			if (addr == WDC_TMO_OFS)
				tmo_reg <= wdata[4:0];
			else if (addr == WDC_CFG_OFS)
				cfg_reg <= wdata[3:0];
			else if (addr == WDC_IEN_OFS)
				ien_reg <= wdata[2:0];
		end
	end

	// ************************************************************
	// Strobe sequencer: write bit high, then low
	// ************************************************************
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			seq_reg    <= WDC_IDLE;
			bit_reg    <= '0;
			shadow_reg <= WDT_CTRL_RST;
			wr_reg     <= 1'b0;
			wdata_reg  <= '0;
			fclr_reg   <= 1'b0;
		end
		else
		begin
			wr_reg   <= 1'b0;
			fclr_reg <= 1'b0;
			case (seq_reg)
			WDC_IDLE:
				if (cmd_wr)
				begin
					if (wdata == WDC_CMD_ARM)
						bit_reg <= 8'h80;
					else if (wdata == WDC_CMD_KICK)
						bit_reg <= 8'h20;
					else if (wdata == WDC_CMD_DISARM)
						bit_reg <= 8'h40;
					else
						bit_reg <= 8'h00;
					if (wdata == WDC_CMD_FCLR)
						fclr_reg <= 1'b1;
					else if (wdata == WDC_CMD_TMO)
					begin
						wr_reg     <= 1'b1;
						wdata_reg  <= {3'b000, tmo_reg};
						shadow_reg <= {3'b000, tmo_reg};
					end
					else if (wdata >= WDC_CMD_ARM && wdata <= WDC_CMD_DISARM)
						seq_reg <= WDC_SET;
				end
			WDC_SET:
			begin
				wr_reg    <= 1'b1;
				wdata_reg <= {bit_reg[7:5], tmo_reg};
				seq_reg   <= WDC_CLR;
			end
			default:
			begin
				wr_reg     <= 1'b1;
				wdata_reg  <= {3'b000, tmo_reg};
				shadow_reg <= {3'b000, tmo_reg};
				seq_reg    <= WDC_IDLE;
			end
			endcase
		end
	end
	assign seq_done = wr_reg && seq_reg == WDC_IDLE && !fclr_reg;

	// ************************************************************
	// Events, restart and read back
	// ************************************************************
	// Previous flag, so only its rising edge raises the status bit;
	// a level would make the write-1 clear useless while it stands
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			flag_prev_reg <= 1'b0;
		else
			flag_prev_reg <= bus.irq_flag;
	end
	assign ev = {bus.chip_rst, bus.irq_flag && !flag_prev_reg, seq_done};
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			stat_reg <= '0;
		else
			stat_reg <= ev | (stat_reg &
				~((wr && addr == WDC_ICLR_OFS) ? wdata[2:0] : 3'b000));
	end

	// Watchdog reset sends the core back to address zero
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			restart_reg <= 1'b0;
			pc_reg      <= WDT_RST_VECTOR;
		end
		else
		begin
			restart_reg <= bus.chip_rst || bus.irq_take;
			if (bus.chip_rst)
				pc_reg <= WDT_RST_VECTOR;
			else if (bus.irq_take)
				pc_reg <= bus.irq_vector;
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_reg <= '0;
		else if (rd)
		begin
			if (addr == WDC_TMO_OFS)
				rdata_reg <= {3'b000, tmo_reg};
			else if (addr == WDC_CFG_OFS)
				rdata_reg <= {4'h0, cfg_reg};
			else if (addr == WDC_STAT_OFS)
				rdata_reg <= {3'b000, bus.running, 1'b0, stat_reg};
			else if (addr == WDC_IEN_OFS)
				rdata_reg <= {5'h00, ien_reg};
			else if (addr == WDC_LINK_OFS)
				rdata_reg <= bus.ctrl_rdata;
			else
				rdata_reg <= '0;
		end
		else
			rdata_reg <= '0;
	end

	assign rdata            = rdata_reg;
	assign irq              = |(stat_reg & ien_reg);
	assign cpu_restart      = restart_reg;
	assign restart_pc       = pc_reg;
	assign bus.ctrl_wr      = wr_reg;
	assign bus.ctrl_wdata   = wdata_reg;
	assign bus.irq_flag_clr = fclr_reg;
	assign bus.irq_en       = cfg_reg[0];
	assign bus.global_en    = cfg_reg[1];
	assign bus.wake_en      = cfg_reg[2];
	assign bus.idle         = cfg_reg[3];
endmodule

// *** bench/wdt_chk.sv ***
// Checker of the watchdog link between controller and device
`timescale 1ns/10ps
module wdt_chk
	import wdt_pkg::*;
#(
	parameter int TICK_CYC = WDT_TICK_CYC
)(
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        ctrl_wr,
	input wire logic [7:0]  ctrl_wdata,
	input wire logic [7:0]  ctrl_rdata,
	input wire logic        irq_flag,
	input wire logic        irq_flag_clr,
	input wire logic        irq_en,
	input wire logic        global_en,
	input wire logic        wake_en,
	input wire logic        idle,
	input wire logic        irq_take,
	input wire logic [15:0] irq_vector,
	input wire logic        wake,
	input wire logic        chip_rst,
	input wire logic        running
);
	// ************************************************************
	// Sequence decode and countdown tracking
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic       arm_s, dis_s, kick_s, ev, flag_d;
	logic [4:0] tmo_l;
	int         cnt;
	// A strobe acts on the write that clears the stored bit
	assign arm_s = ctrl_wr && ctrl_rdata[7] && !ctrl_wdata[7];
	assign dis_s = ctrl_wr && ctrl_rdata[6] && !ctrl_wdata[6];
	assign kick_s = ctrl_wr && ctrl_rdata[5] && !ctrl_wdata[5];
	assign ev = chip_rst || (irq_flag && !flag_d);
	// Flag seen while still set gives no edge, so the bench clears it
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= 0;
			tmo_l <= 5'h00;
			flag_d <= 1'b0;
		end
		else
		begin
			flag_d <= irq_flag;
			if (arm_s || kick_s)
				tmo_l <= ctrl_wdata[4:0];
			else if (ev)
				tmo_l <= ctrl_rdata[4:0];
			cnt <= (arm_s || kick_s || ev || !running) ? 0 : cnt + 1;
		end
	end
	sequence s_arm;
		ctrl_wr && ctrl_wdata[7] ##1 arm_s && !dis_s;
	endsequence
	property p_arm; s_arm |=> running; endproperty
	a_arm: assert property (p_arm) else $error("arm did not start");
	property p_dis; dis_s |=> !running; endproperty
	a_dis: assert property (p_dis) else $error("disarm ignored");
	property p_off; !running && !arm_s |=> !running; endproperty
	a_off: assert property (p_off) else $error("started unarmed");
	property p_on;
		running && !dis_s && !chip_rst |=> running || chip_rst;
	endproperty
	a_on: assert property (p_on) else $error("countdown stopped");
	property p_rst; chip_rst |=> !chip_rst; endproperty
	a_rst: assert property (p_rst) else $error("reset pulse long");
	property p_flag; irq_flag && !irq_flag_clr |=> irq_flag; endproperty
	a_flag: assert property (p_flag) else $error("flag dropped");
	property p_take;
		irq_take == (irq_flag && irq_en && global_en && !idle)
			&& (!irq_take || irq_vector == WDT_VECTOR);
	endproperty
	a_take: assert property (p_take) else $error("take wrong");
	property p_wake; wake == (irq_flag && idle && wake_en); endproperty
	a_wake: assert property (p_wake) else $error("wake wrong");
	property p_early; ev |-> cnt + 2 >= tmo_l * TICK_CYC; endproperty
	a_early: assert property (p_early) else $error("expiry early");
	property p_late;
		running && cnt > (tmo_l + 1) * TICK_CYC + 2 |-> irq_flag;
	endproperty
	a_late: assert property (p_late) else $error("expiry late");
endmodule

// *** bench/watchdog_timer_test.sv ***
// Self-checking bench for both watchdog ends
`timescale 1ns/10ps
module watchdog_timer_test
	import wdt_pkg::*;
;
	// ************************************************************
	// Signals, ends and checker
	// ************************************************************
	localparam int T = 8;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        act_sel = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata;
	logic        irq, cpu_restart;
	logic [15:0] restart_pc;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          n, cyc = 0;
	int          row [3][3] = '{'{0, 0, 11}, '{7, 56, 67}, '{31, 248, 259}};
	wdt_if u_wdt_if ();
	wdt_core #(.TICK_CYC(T)) u_wdt_core (.core_clk(core_clk),
		.arst_n(arst_n), .expiry_action_select(act_sel), .bus(u_wdt_if));
	wdt_ctl u_wdt_ctl (.core_clk(core_clk), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
		.cpu_restart(cpu_restart), .restart_pc(restart_pc), .bus(u_wdt_if));
	wdt_chk #(.TICK_CYC(T)) u_wdt_chk (.core_clk(core_clk), .arst_n(arst_n),
		.ctrl_wr(u_wdt_if.ctrl_wr), .ctrl_wdata(u_wdt_if.ctrl_wdata),
		.ctrl_rdata(u_wdt_if.ctrl_rdata), .irq_flag(u_wdt_if.irq_flag),
		.irq_flag_clr(u_wdt_if.irq_flag_clr), .irq_en(u_wdt_if.irq_en),
		.global_en(u_wdt_if.global_en), .wake_en(u_wdt_if.wake_en),
		.idle(u_wdt_if.idle), .irq_take(u_wdt_if.irq_take),
		.irq_vector(u_wdt_if.irq_vector), .wake(u_wdt_if.wake),
		.chip_rst(u_wdt_if.chip_rst), .running(u_wdt_if.running));
	// Free clock and a cycle ceiling that cuts a hang short
	initial forever #10 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			error_cnt++;
			test_done();
		end
	end
	// Register port cycles; read data sampled once the edge has landed
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask
	task automatic chk(input string s, input logic [15:0] e, v);
		checks_done++;
		if (v !== e)
		begin
			$display("Error %s expected %h seen %h", s, e, v);
			error_cnt++;
		end
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	// Sequencer is busy after a command, so leave it three cycles
	task automatic cmd(input logic [7:0] c);
		wr_reg(WDC_CMD_OFS, c);
		repeat (3) @(posedge core_clk);
	endtask
	task automatic wait_ev(input int lim);
		n = 0;
		while (u_wdt_if.irq_flag !== 1'b1 && cpu_restart !== 1'b1 && n < lim)
		begin
			@(posedge core_clk);
			#1 n++;
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd_chk(WDC_STAT_OFS, 8'h00);
		rd_chk(WDC_LINK_OFS, WDT_CTRL_RST);
		rd_chk(4'hF, 8'h00);
		chk("irq", 1'b0, irq);
		// Timeout field sets the countdown, one tick of slack allowed
		for (int i = 0; i < 3; i++)
		begin
			wr_reg(WDC_TMO_OFS, 8'(row[i][0]));
			cmd(WDC_CMD_ARM);
			wait_ev(400);
			chk("late", 1'b1, n <= row[i][2]);
			chk("early", 1'b1, n >= row[i][1]);
			@(posedge core_clk);
			rd_chk(WDC_STAT_OFS, 8'h13);
			rd_chk(WDC_LINK_OFS, 8'(row[i][0]));
			cmd(WDC_CMD_DISARM);
			cmd(WDC_CMD_FCLR);
			wr_reg(WDC_ICLR_OFS, 8'h07);
			rd_chk(WDC_STAT_OFS, 8'h00);
		end
		// New timeout waits for the expiry that reloads it
		wr_reg(WDC_IEN_OFS, 8'h02);
		wr_reg(WDC_TMO_OFS, 8'h03);
		cmd(WDC_CMD_ARM);
		wr_reg(WDC_TMO_OFS, 8'h01);
		cmd(WDC_CMD_TMO);
		wait_ev(100);
		chk("old tmo", 1'b1, n + 5 >= 3 * T);
		@(posedge core_clk);
		#1 chk("irq", 1'b1, irq);
		cmd(WDC_CMD_FCLR);
		wait_ev(100);
		chk("new tmo", 1'b1, n + 4 <= 2 * T + 3);
		cmd(WDC_CMD_DISARM);
		wr_reg(WDC_IEN_OFS, 8'h00);
		#1 chk("mask", 1'b0, irq);
		wr_reg(WDC_IEN_OFS, 8'h02);
		wr_reg(WDC_ICLR_OFS, 8'h02);
		#1 chk("iclr", 1'b0, irq);
		wr_reg(WDC_CFG_OFS, 8'h03);
		#1 chk("take", 1'b1, u_wdt_if.irq_take);
		chk("vec", WDT_VECTOR, u_wdt_if.irq_vector);
		wr_reg(WDC_CFG_OFS, 8'h0B);
		#1 chk("wake", 1'b0, u_wdt_if.wake);
		wr_reg(WDC_CFG_OFS, 8'h0F);
		#1 chk("wake", 1'b1, u_wdt_if.wake);
		wr_reg(WDC_CFG_OFS, 8'h00);
		cmd(WDC_CMD_FCLR);
		// Kicks closer than the countdown hold off expiry
		wr_reg(WDC_TMO_OFS, 8'h02);
		cmd(WDC_CMD_ARM);
		repeat (8) cmd(WDC_CMD_KICK);
		chk("kicked", 1'b0, u_wdt_if.irq_flag);
		wait_ev(100);
		chk("unkicked", 1'b1, u_wdt_if.irq_flag);
		cmd(WDC_CMD_DISARM);
		cmd(WDC_CMD_FCLR);
		// Reset mode alone starts nothing, expiry restarts at zero
		act_sel <= 1'b1;
		repeat (300) @(posedge core_clk);
		#1 chk("off", 1'b0, u_wdt_if.irq_flag | cpu_restart);
		wr_reg(WDC_TMO_OFS, 8'h00);
		cmd(WDC_CMD_ARM);
		wait_ev(40);
		chk("restart", 1'b1, cpu_restart);
		chk("pc", WDT_RST_VECTOR, restart_pc);
		chk("no flag", 1'b0, u_wdt_if.irq_flag);
		cmd(WDC_CMD_DISARM);
		test_done();
	end
endmodule
